//--- hdl/scc_coproc_port.sv
// register access port of the system control coprocessor
// assumes the core holds each instruction for one cycle with valid high
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"

module scc_coproc_port
	import scc_pkg::*;
#(
	// arbitrary neutral identity values
	parameter logic [7:0] IMPLEMENTER = 8'h5A,
	parameter logic [11:0] PART_NUMBER = 12'h123,
	parameter logic [3:0] LAYOUT_REV = 4'h0
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	// strap
	input wire logic vector_high_init_pin,
	// core side
	input wire scc_req_t req,
	output scc_rsp_t rsp,
	// state shown to the rest of the coprocessor
	output logic vector_high_ff
);

	// ======================================================
	// decode
	function automatic logic is_privileged(input logic [4:0] mode);
		return mode != `SCC_MODE_USER;
	endfunction : is_privileged

	function automatic logic [11:0] geo_field();
		return {`SCC_GEO_RSVD, `SCC_GEO_SIZE, `SCC_GEO_ASSOC, `SCC_GEO_MULT, `SCC_GEO_LEN};
	endfunction : geo_field

	logic trap_cond;
	logic accept;
	logic [31:0] nxt_rd_data;
	logic [31:0] id_word;
	logic [31:0] geo_word;
	scc_state_t state_ff;
	scc_rsp_t rsp_ff;
	logic strap_pending_ff;

	assign id_word = {IMPLEMENTER, `SCC_SPEC_REV, `SCC_ARCH_CODE, PART_NUMBER, LAYOUT_REV};
	// class and reserved top bits; harvard bit
	assign geo_word = {3'h0, `SCC_CTYPE_CLASS, `SCC_HARVARD, geo_field(), geo_field()};

	assign trap_cond = req.valid && (req.is_data_op || req.is_load_store
		|| (req.is_transfer && !is_privileged(req.mode)));
	assign accept = req.valid && req.is_transfer && is_privileged(req.mode)
		&& !req.is_data_op && !req.is_load_store;

	// primary select, second opcode picks the word
	// every other location reads zero and ignores writes, so no value harms state
	always_comb
	begin
		nxt_rd_data = 32'h0;
		if (req.primary_reg_select == `SCC_REG_ID)
		begin
			// cache geometry, id for all other codes
			if (req.opc2 == `SCC_OP2_CACHE)
				nxt_rd_data = geo_word;
			else
				nxt_rd_data = id_word;
		end
	end

	// ======================================================
	// answer sequencing
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= SCC_ST_IDLE;
			rsp_ff <= '0;
		end
		else if (clk_en)
		begin
			rsp_ff <= '0;
			state_ff <= SCC_ST_IDLE;
			case (1'b1)
				trap_cond:
				begin
					rsp_ff.undef_trap <= 1'b1;
					state_ff <= SCC_ST_TRAP;
				end
				accept:
				begin
					state_ff <= SCC_ST_ANSWER;
					if (req.dir_read)
					begin
						rsp_ff.rd_valid <= 1'b1;
						rsp_ff.rd_data <= nxt_rd_data;
					end
					else
						rsp_ff.wr_done <= 1'b1;
				end
				default:
					state_ff <= SCC_ST_IDLE;
			endcase
		end
	end

	assign rsp = rsp_ff;

	// ======================================================
	// high-vector bit, caught from the pin just after reset release
	// async reset may only load a constant, so the strap is taken on the first edge with clk_en high
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_pending_ff <= 1'b1;
			vector_high_ff <= 1'b0;
		end
		else if (clk_en && strap_pending_ff)
		begin
			strap_pending_ff <= 1'b0;
			vector_high_ff <= vector_high_init_pin;
		end
	end

	// ======================================================
	// checks
	a_trap_next: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && trap_cond |=> rsp.undef_trap && !rsp.rd_valid)
		else $error("refused instruction did not trap");
	a_priv_read: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && accept && req.dir_read |=> rsp.rd_valid && !rsp.undef_trap)
		else $error("privileged read not answered");
	a_id_word: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && accept && req.dir_read && req.primary_reg_select == 4'h0 && req.opc2 != 3'h1
		|=> rsp.rd_data == {IMPLEMENTER, 8'h02, PART_NUMBER, LAYOUT_REV})
		else $error("id word wrong");
	a_geo_word: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && accept && req.dir_read && req.primary_reg_select == 4'h0 && req.opc2 == 3'h1
		|=> rsp.rd_data == 32'h0D132132)
		else $error("cache geometry word wrong");
	a_write_dir: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && accept && !req.dir_read |=> rsp.wr_done && !rsp.rd_valid)
		else $error("write shown as read");
	a_quiet_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !req.valid |=> rsp == '0)
		else $error("answer without request");
	a_strap_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && strap_pending_ff |=> vector_high_ff == $past(vector_high_init_pin)
		&& !strap_pending_ff)
		else $error("vector bit not strapped");
	a_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
		!clk_en |=> $stable(rsp))
		else $error("answer changed while frozen");

	// ======================================================
	// answer shape and high-vector bit checks
	a_state_onehot: assert property (@(posedge clk_sys) disable iff (!resetn)
		$onehot(state_ff))
		else $error("answer state not one-hot");

	a_state_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_ff == SCC_ST_ANSWER |-> rsp.rd_valid || rsp.wr_done)
		else $error("answer state without answer");

	a_state_trap: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_ff == SCC_ST_TRAP |-> rsp.undef_trap)
		else $error("trap state without trap");

	a_trap_nodata: assert property (@(posedge clk_sys) disable iff (!resetn)
		rsp.undef_trap |-> rsp.rd_data == 32'h0 && !rsp.wr_done)
		else $error("trap carried data");

	a_pulse_single: assert property (@(posedge clk_sys) disable iff (!resetn)
		$onehot0({rsp.rd_valid, rsp.wr_done, rsp.undef_trap}))
		else $error("more than one answer kind");

	a_data_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
		!rsp.rd_valid |-> rsp.rd_data == 32'h0)
		else $error("read data without read");

	a_user_noxfer: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && req.valid && req.is_transfer && req.mode == 5'h10
		|=> !rsp.rd_valid && !rsp.wr_done)
		else $error("user transfer accepted");

	a_dataop_trap: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && req.valid && req.is_data_op |=> rsp.undef_trap)
		else $error("data operation not trapped");

	a_ldst_trap: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && req.valid && req.is_load_store |=> rsp.undef_trap)
		else $error("load or store not trapped");

	a_other_reg: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && accept && req.dir_read && req.primary_reg_select != 4'h0 |=> rsp.rd_data == 32'h0)
		else $error("other register read not zero");

	a_write_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && accept && !req.dir_read |=> rsp.rd_data == 32'h0)
		else $error("write returned data");

	a_vector_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		!strap_pending_ff |=> $stable(vector_high_ff))
		else $error("vector bit moved after strap");

	a_strap_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
		strap_pending_ff && !clk_en |=> $stable(vector_high_ff) && strap_pending_ff)
		else $error("strap taken while frozen");

	// ======================================================
	// field checks on reads of register 0
	logic id_read;
	logic geo_read;
	assign id_read = clk_en && accept && req.dir_read && req.primary_reg_select == 4'h0
		&& req.opc2 != 3'h1;
	assign geo_read = clk_en && accept && req.dir_read && req.primary_reg_select == 4'h0
		&& req.opc2 == 3'h1;

	a_id_arch: assert property (@(posedge clk_sys) disable iff (!resetn)
		id_read |=> rsp.rd_data[23:16] == 8'h02)
		else $error("id revision or architecture wrong");

	a_id_maker: assert property (@(posedge clk_sys) disable iff (!resetn)
		id_read |=> rsp.rd_data[31:24] == IMPLEMENTER && rsp.rd_data[15:4] == PART_NUMBER)
		else $error("id maker or part wrong");

	a_geo_top: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[31:29] == 3'h0 && rsp.rd_data[28:25] == 4'h6)
		else $error("cache class wrong");

	a_geo_harvard: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[24] == 1'b1)
		else $error("separate cache bit wrong");

	a_geo_rsvd: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[23:21] == 3'h0 && rsp.rd_data[11:9] == 3'h0)
		else $error("geometry reserved bits wrong");

	a_geo_size: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[20:18] == 3'h4 && rsp.rd_data[8:6] == 3'h4)
		else $error("cache size code wrong");

	a_geo_assoc: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[17:15] == 3'h6 && rsp.rd_data[5:3] == 3'h6)
		else $error("associativity code wrong");

	a_geo_mult: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[14] == 1'b0 && rsp.rd_data[2] == 1'b0)
		else $error("multiplier bit wrong");

	a_geo_len: assert property (@(posedge clk_sys) disable iff (!resetn)
		geo_read |=> rsp.rd_data[13:12] == 2'h2 && rsp.rd_data[1:0] == 2'h2)
		else $error("line length code wrong");

endmodule : scc_coproc_port
`default_nettype wire

//--- hdl/scc_defines.svh
// constants for the system control coprocessor register port
// assumes inclusion by bare name from package and design files
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// register location of the identification words
`define SCC_REG_ID 4'h0
`define SCC_OP2_CACHE 3'h1
// identification word fields
`define SCC_SPEC_REV 4'h0
`define SCC_ARCH_CODE 4'h2
// cache geometry word fields
`define SCC_CTYPE_CLASS 4'h6
`define SCC_HARVARD 1'h1
`define SCC_GEO_RSVD 3'h0
`define SCC_GEO_SIZE 3'h4
`define SCC_GEO_ASSOC 3'h6
`define SCC_GEO_MULT 1'h0
`define SCC_GEO_LEN 2'h2
// processor mode that is unprivileged
`define SCC_MODE_USER 5'h10

`endif

//--- hdl/scc_pkg.sv
// types for the system control coprocessor register port
// assumes scc_defines.svh is on the include path
package scc_pkg;
`include "scc_defines.svh"

	// one coprocessor instruction as presented by the core
	typedef struct packed {
		logic valid;
		logic is_transfer;
		logic is_data_op;
		logic is_load_store;
		logic dir_read;
		logic [2:0] opc1;
		logic [3:0] primary_reg_select;
		logic [3:0] secondary_reg_select;
		logic [2:0] opc2;
		logic [4:0] mode;
	} scc_req_t;

	// answer to the core
	typedef struct packed {
		logic rd_valid;
		logic wr_done;
		logic undef_trap;
		logic [31:0] rd_data;
	} scc_rsp_t;

	typedef enum logic [2:0] {
		SCC_ST_IDLE = 3'b001,
		SCC_ST_ANSWER = 3'b010,
		SCC_ST_TRAP = 3'b100
	} scc_state_t;

endpackage : scc_pkg

//--- bench/scc_core_model.sv
// core model: presents one coprocessor instruction per request
// assumes the bench raises go for one cycle per instruction
`timescale 1ns/1ps
`default_nettype none
module scc_core_model
	import scc_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// bench side
	input wire logic go,
	input wire scc_req_t insn,
	// device side
	output var scc_req_t req
);
	// ==========
	// issue
	// opc1 comes zero from the rows, opc2 is set per row
	always_ff @(posedge clk_sys)
		req <= go ? insn : '0;
endmodule : scc_core_model
`default_nettype wire

//--- bench/test_sysctl_coproc_id_regs.sv
// bench for the coprocessor identification port
// assumes the design answers within two cycles of the instruction
`timescale 1ns/1ps
`default_nettype none
module test_sysctl_coproc_id_regs
	import scc_pkg::*;
;
	typedef struct packed {scc_req_t r; scc_rsp_t e;} scc_row_t;
	logic clk_sys = 1'h0;
	logic resetn = 1'h0;
	logic pin = 1'h1;
	logic go = 1'h0;
	logic ce = 1'h1;
	logic vh;
	scc_req_t insn = '0;
	scc_req_t req;
	scc_rsp_t rsp;
	int error_cnt = 0;
	int compares = 0;
	scc_row_t rows [10];
	// ==========
	// expected words, arbitrary identity values
	localparam logic [31:0] ID = {8'h5A, 4'h0, 4'h2, 12'h123, 4'h0};
	localparam logic [11:0] GEO = {3'h0, 3'h4, 3'h6, 1'h0, 2'h2};
	localparam logic [31:0] CT = {3'h0, 4'h6, 1'h1, GEO, GEO};
	localparam logic [34:0] TRAP = {3'h1, 32'h0};
	scc_core_model core (.clk_sys(clk_sys), .go(go), .insn(insn), .req(req));
	scc_coproc_port #(.IMPLEMENTER(8'h5A), .PART_NUMBER(12'h123), .LAYOUT_REV(4'h0)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .clk_en(ce),
		.vector_high_init_pin(pin), .req(req), .rsp(rsp), .vector_high_ff(vh));
	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end
	function automatic scc_req_t mk(input logic [3:0] k, input logic [2:0] op2,
		input logic [4:0] md);
		mk = '0;
		mk.valid = 1'h1;
		{mk.is_transfer, mk.is_data_op, mk.is_load_store, mk.dir_read} = k;
		mk.opc2 = op2;
		mk.mode = md;
	endfunction : mk
	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic run(input scc_row_t w);
		int n;
		@(posedge clk_sys) #1;
		insn = w.r;
		go = 1'h1;
		@(posedge clk_sys) #1;
		go = 1'h0;
		for (n = 0; n < 4 && !(rsp.rd_valid | rsp.wr_done | rsp.undef_trap); n++)
			@(posedge clk_sys) #1;
		if (n == 4)
		begin
			error_cnt++;
			$display("Error %0t no answer within bound", $time);
			summarize();
		end
		chk(rsp, w.e);
	endtask : run
	task automatic freeze;
		@(posedge clk_sys) #1;
		insn = rows[0].r;
		go = 1'h1;
		@(posedge clk_sys) #1;
		go = 1'h0;
		@(posedge clk_sys) #1;
		ce = 1'h0;
		repeat (2) @(posedge clk_sys);
		#1 chk(rsp, rows[0].e);
		ce = 1'h1;
		@(posedge clk_sys) #1;
		chk(rsp, '0);
		$display("freeze test done");
	endtask : freeze
	task automatic rst(input logic v);
		@(posedge clk_sys) #1;
		resetn = 1'h0;
		pin = v;
		repeat (3) @(posedge clk_sys);
		#1 chk(rsp, '0);
		chk({34'h0, vh}, '0);
		resetn = 1'h1;
		@(posedge clk_sys) #1;
		chk({34'h0, vh}, {34'h0, v});
		$display("reset test done");
	endtask : rst
	// ==========
	// main sequence
	initial
	begin
		rows[0] = {mk(4'h9, 3'h0, 5'h13), 3'h4, ID};
		rows[1] = {mk(4'h9, 3'h1, 5'h13), 3'h4, CT};
		rows[2] = {mk(4'h9, 3'h7, 5'h1F), 3'h4, ID};
		rows[3] = {mk(4'h8, 3'h0, 5'h13), 3'h2, 32'h0};
		rows[4] = rows[0];
		rows[5] = {mk(4'h9, 3'h0, 5'h10), TRAP};
		rows[6] = {mk(4'h4, 3'h0, 5'h13), TRAP};
		rows[7] = {mk(4'h2, 3'h0, 5'h13), TRAP};
		rows[8] = {mk(4'h8, 3'h1, 5'h10), TRAP};
		rows[9] = {mk(4'h9, 3'h0, 5'h13), 3'h4, 32'h0};
		rows[9].r.primary_reg_select = 4'h1;
		repeat (20) @(posedge clk_sys);
		#1 resetn = 1'h1;
		@(posedge clk_sys) #1;
		chk({34'h0, vh}, 35'h1);
		foreach (rows[i])
		begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		freeze();
		rst(1'h0);
		rst(1'h1);
		summarize();
	end
endmodule : test_sysctl_coproc_id_regs
`default_nettype wire
